// [core/dpm_map_mid.v]
// Behaviour
// - Bits 6:4 of each register give the odd code point's priority, IPv4 and IPv6.
// - Bits 2:0 of each register give the even code point's priority.
// - Priority fields are read/write and reset to zero.
// - Byte-wide registers; 0x034F serves 0x1E/0x1F, each next byte the next pair.
// - The register at 0x035B serves code points 0x36 and 0x37.
// - The full table covers all sixty-four codes, ending at 0x035F for 0x3E/0x3F.
`timescale 1ns/100ps
`include "dpm_regs.vh"

module dpm_map_mid #(
  parameter NUM_PAIRS = `DPM_NUM_PAIRS
) (
  input  wire                   ref_clk,
  input  wire                   reset_n,
  input  wire [15:0]            reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output wire [7:0]             reg_rdata,
  output wire                   reg_hit,
  output wire                   reg_miss,
  input  wire                   lkp_valid,
  input  wire [5:0]             lkp_code,
  output wire                   lkp_done,
  output wire                   lkp_hit,
  output wire [2:0]             lkp_prio,
  output wire [NUM_PAIRS*6-1:0] prio_flat
);

  // ---------------------------------------------------------------------
  // Register address decode.
  // ---------------------------------------------------------------------

  // Index of the pair register selected by a byte address, or the
  // out-of-range value 4'hf when this bank does not own the address.
  function [3:0] addr_to_index;
    input [15:0] addr;
    begin
      case (addr)
        `DPM_ADDR_PAIR_1E: addr_to_index = 4'h0;
        `DPM_ADDR_PAIR_20: addr_to_index = 4'h1;
        `DPM_ADDR_PAIR_22: addr_to_index = 4'h2;
        `DPM_ADDR_PAIR_24: addr_to_index = 4'h3;
        `DPM_ADDR_PAIR_26: addr_to_index = 4'h4;
        `DPM_ADDR_PAIR_28: addr_to_index = 4'h5;
        `DPM_ADDR_PAIR_2A: addr_to_index = 4'h6;
        `DPM_ADDR_PAIR_2C: addr_to_index = 4'h7;
        `DPM_ADDR_PAIR_2E: addr_to_index = 4'h8;
        `DPM_ADDR_PAIR_30: addr_to_index = 4'h9;
        `DPM_ADDR_PAIR_32: addr_to_index = 4'ha;
        `DPM_ADDR_PAIR_34: addr_to_index = 4'hb;
        `DPM_ADDR_PAIR_36: addr_to_index = 4'hc;
        default:           addr_to_index = 4'hf;
      endcase
    end
  endfunction

  wire [3:0] acc_index;
  wire       acc_owned;
  wire       acc_any;

  assign acc_index = addr_to_index(reg_addr);
  assign acc_owned = (acc_index != 4'hf);
  assign acc_any   = reg_wr | reg_rd;

  // ---------------------------------------------------------------------
  // Pair registers.
  // ---------------------------------------------------------------------

  wire [7:0] pair_rd   [0:NUM_PAIRS-1];
  wire [2:0] pair_odd  [0:NUM_PAIRS-1];
  wire [2:0] pair_even [0:NUM_PAIRS-1];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PAIRS; gi = gi + 1) begin : g_pair
      localparam [3:0] PAIR_IDX = gi;
      wire sel_wr;

      assign sel_wr = reg_wr & acc_owned & (acc_index == PAIR_IDX);

      dpm_pair_reg u_pair (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .wr_en     (sel_wr),
        .wr_data   (reg_wdata),
        .rd_data   (pair_rd[gi]),
        .prio_odd  (pair_odd[gi]),
        .prio_even (pair_even[gi])
      );

      // The flat table lists pairs from the lowest code upward, even field
      // in the low three bits of each six-bit slot.
      assign prio_flat[gi*6 +: 3]     = pair_even[gi];
      assign prio_flat[gi*6 + 3 +: 3] = pair_odd[gi];
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Read path and access status.
  // ---------------------------------------------------------------------

  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg        hit_q;
  reg        miss_q;

  always @* begin
    rdata_d = 8'h00;
    if (reg_rd && acc_owned) begin
      rdata_d = pair_rd[acc_index];
    end
  end

  // Read data only stands in the cycle after the strobe and is zero
  // otherwise, so an unowned address answers with zero. Another bank
  // sharing the bus can then be merged with a plain OR.
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      hit_q   <= 1'b0;
      miss_q  <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= acc_any & acc_owned;
      miss_q  <= acc_any & ~acc_owned;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit   = hit_q;
  assign reg_miss  = miss_q;

  // ---------------------------------------------------------------------
  // Priority lookup for the frame classifier.
  // ---------------------------------------------------------------------

  wire       code_in_bank;
  wire [5:0] code_offset;
  wire [3:0] code_index;

  // Codes outside 0x1E..0x37 belong to the neighbouring banks of the full
  // sixty-four entry table; this bank reports them as a miss with priority
  // zero so that the results of all banks can be ORed together.
  assign code_in_bank = (lkp_code >= `DPM_CODE_FIRST) &&
                        (lkp_code <= `DPM_CODE_LAST);
  assign code_offset  = lkp_code - `DPM_CODE_FIRST;
  assign code_index   = code_offset[4:1];

  reg  [2:0] prio_d;
  reg  [2:0] prio_q;
  reg        done_q;
  reg        lhit_q;

  always @* begin
    prio_d = `DPM_PRIO_RESET;
    if (lkp_valid && code_in_bank) begin
      // The first covered code is even, so bit zero of the code itself
      // picks the field inside the pair.
      if (lkp_code[0]) begin
        prio_d = pair_odd[code_index];
      end else begin
        prio_d = pair_even[code_index];
      end
    end
  end

  // A write in the same cycle as a lookup is seen by the next lookup only;
  // the classifier gets a consistent old value rather than a torn one.
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      prio_q <= `DPM_PRIO_RESET;
      done_q <= 1'b0;
      lhit_q <= 1'b0;
    end else begin
      prio_q <= prio_d;
      done_q <= lkp_valid;
      lhit_q <= lkp_valid & code_in_bank;
    end
  end

  assign lkp_prio = prio_q;
  assign lkp_done = done_q;
  assign lkp_hit  = lhit_q;

endmodule

// [pkg/dpm_regs.vh]
`ifndef DPM_REGS_VH
`define DPM_REGS_VH

// Byte addresses of the mapping registers, one per pair of code points.
`define DPM_ADDR_PAIR_1E     16'h034f
`define DPM_ADDR_PAIR_20     16'h0350
`define DPM_ADDR_PAIR_22     16'h0351
`define DPM_ADDR_PAIR_24     16'h0352
`define DPM_ADDR_PAIR_26     16'h0353
`define DPM_ADDR_PAIR_28     16'h0354
`define DPM_ADDR_PAIR_2A     16'h0355
`define DPM_ADDR_PAIR_2C     16'h0356
`define DPM_ADDR_PAIR_2E     16'h0357
`define DPM_ADDR_PAIR_30     16'h0358
`define DPM_ADDR_PAIR_32     16'h0359
`define DPM_ADDR_PAIR_34     16'h035a
`define DPM_ADDR_PAIR_36     16'h035b

// End of the whole sixty-four entry table, served by other banks.
`define DPM_ADDR_TABLE_LAST  16'h035f
`define DPM_CODE_TABLE_LAST  6'h3f

// Field layout of every mapping register.
`define DPM_ODD_MSB          6
`define DPM_ODD_LSB          4
`define DPM_EVEN_MSB         2
`define DPM_EVEN_LSB         0
`define DPM_PRIO_W           3
`define DPM_PAIR_RESET       8'h00
`define DPM_PRIO_RESET       3'h0

// Code points covered by this bank.
`define DPM_CODE_FIRST       6'h1e
`define DPM_CODE_LAST        6'h37
`define DPM_NUM_PAIRS        13

`endif

// [core/dpm_pair_reg.v]
`timescale 1ns/100ps
`include "dpm_regs.vh"

module dpm_pair_reg (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  output wire [7:0] rd_data,
  output wire [2:0] prio_odd,
  output wire [2:0] prio_even
);

  reg [2:0] odd_q;
  reg [2:0] even_q;

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      odd_q  <= `DPM_PRIO_RESET;
      even_q <= `DPM_PRIO_RESET;
    end else if (wr_en) begin
      odd_q  <= wr_data[`DPM_ODD_MSB:`DPM_ODD_LSB];
      even_q <= wr_data[`DPM_EVEN_MSB:`DPM_EVEN_LSB];
    end
  end

  // Bits seven and three are not stored, so they always read back as zero.
  assign rd_data   = {1'b0, odd_q, 1'b0, even_q};
  assign prio_odd  = odd_q;
  assign prio_even = even_q;

endmodule

// [tb/dpm_map_mid_chk.sv]
`timescale 1ns/100ps
module dpm_map_mid_chk #(parameter NUM_PAIRS = 13) (
  input logic                   ref_clk,
  input logic                   reset_n,
  input logic [15:0]            reg_addr,
  input logic [7:0]             reg_wdata,
  input logic                   reg_wr,
  input logic                   reg_rd,
  input logic [7:0]             reg_rdata,
  input logic                   reg_hit,
  input logic                   reg_miss,
  input logic                   lkp_valid,
  input logic [5:0]             lkp_code,
  input logic                   lkp_done,
  input logic                   lkp_hit,
  input logic [2:0]             lkp_prio,
  input logic [NUM_PAIRS*6-1:0] prio_flat
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire own_addr = reg_addr >= 16'h034f && reg_addr <= 16'h035b;
  a_rsvd_reads_zero: assert property (reg_rdata[7] == 0 && reg_rdata[3] == 0) else $error("reserved bit");
  a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray rdata");
  a_owned_hit: assert property ((reg_wr || reg_rd) && own_addr |=> reg_hit && !reg_miss) else $error("no hit");
  a_unowned_miss: assert property ((reg_wr || reg_rd) && !own_addr |=> reg_miss && !reg_hit) else $error("no miss");
  a_first_pair_wr: assert property (reg_wr && reg_addr == 16'h034f
    |=> prio_flat[5:0] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}) else $error("pair 1e");
  a_last_pair_wr: assert property (reg_wr && reg_addr == 16'h035b
    |=> prio_flat[NUM_PAIRS*6-1 -: 6] == {$past(reg_wdata[6:4]), $past(reg_wdata[2:0])}) else $error("pair 36");
  a_read_pair_2c: assert property (reg_rd && reg_addr == 16'h0356
    |=> reg_rdata == {1'b0, $past(prio_flat[47:45]), 1'b0, $past(prio_flat[44:42])}) else $error("pair 2c");
  a_lookup_odd: assert property (lkp_valid && lkp_code == 6'h37
    |=> lkp_done && lkp_hit && lkp_prio == $past(prio_flat[NUM_PAIRS*6-1 -: 3])) else $error("lookup 37");
  c_write: cover property (reg_wr && own_addr);
  c_miss: cover property (reg_miss);
  c_lookup: cover property (lkp_hit && lkp_prio != 3'h0);
endmodule
bind dpm_map_mid dpm_map_mid_chk #(.NUM_PAIRS(NUM_PAIRS)) u_chk (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .reg_hit, .reg_miss, .lkp_valid, .lkp_code, .lkp_done, .lkp_hit, .lkp_prio,
  .prio_flat);

// [tb/dpm_map_mid_tb_top.sv]
`timescale 1ns/100ps
module dpm_map_mid_tb_top;
  logic        ref_clk = 0;
  logic        reset_n = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0;
  logic        reg_wr = 0;
  logic        reg_rd = 0;
  logic        lkp_valid = 0;
  logic [5:0]  lkp_code = 0;
  wire  [7:0]  reg_rdata;
  wire         reg_hit, reg_miss, lkp_done, lkp_hit;
  wire  [2:0]  lkp_prio;
  wire  [77:0] prio_flat;
  logic [15:0] bad [4] = '{16'h034e, 16'h035c, 16'h035f, 16'h0000};
  int          n_mismatch = 0;
  int          checks = 0;
  dpm_map_mid DUT (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_hit,
    .reg_miss, .lkp_valid, .lkp_code, .lkp_done, .lkp_hit, .lkp_prio, .prio_flat);
  always #5 ref_clk = ~ref_clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Every access starts 1 ns after an edge, so consecutive calls run back to back.
  task op(input logic w, input logic [15:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 0;
    reg_rd <= 0;
    #1;
  endtask
  task lk(input logic [5:0] c);
    lkp_valid <= 1;
    lkp_code <= c;
    @(posedge ref_clk);
    lkp_valid <= 0;
    #1;
  endtask
  // Distinct pattern per pair, so an aliased address shows up on read-back.
  function automatic logic [7:0] val(input int i);
    return 8'((i + 1) * 37);
  endfunction
  initial begin
    int i;
    logic [7:0] e;
    logic in;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    #1;
    for (i = 0; i < 13; i++) begin
      op(0, 16'h034f + 16'(i), 0);
      chk(reg_rdata, 8'h00);
      op(1, 16'h034f + 16'(i), val(i) | 8'h88);
      chk({7'h0, reg_hit}, 8'h01);
      op(0, 16'h034f + 16'(i), 0);
      chk(reg_rdata, val(i) & 8'h77);
    end
    for (i = 0; i < 4; i++) begin
      op(1, bad[i], 8'hff);
      op(0, bad[i], 0);
      chk({reg_miss, reg_rdata[6:0]}, 8'h80);
    end
    for (i = 0; i < 13; i++) begin
      op(0, 16'h034f + 16'(i), 0);
      chk(reg_rdata, val(i) & 8'h77);
    end
    for (i = 28; i < 64; i++) begin
      lk(6'(i));
      in = i >= 30 && i <= 55;
      e = in ? val((i - 30) / 2) & 8'h77 : 8'h00;
      chk({3'h0, lkp_done, lkp_hit, lkp_prio}, {4'h1, in, i[0] ? e[6:4] : e[2:0]});
    end
    reset_n <= 0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    #1;
    op(0, 16'h035b, 0);
    chk(reg_rdata, 8'h00);
    close_out;
  end
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end
endmodule
